// ===== hw/cmpvr_ctrl.sv
// comparator and voltage reference control with an APB register slave
// Operation
// - result bits read-only at control bits 7:6
// - mode 110 drives raw results onto pins
// - direction bits still gate routed pin drivers
// - analog-input pins read zero from port
// - flag sets when results differ from copy
// - change flag sits at flag bit 6
// - writing zero clears flag, one sets it
// - request needs flag and three enables set
// - change during control access may be missed
// - control access refreshes the latched result copy
// - persisting mismatch keeps setting the flag
// - comparators run in sleep, flag wakes
// - wake leaves the control register unchanged
// - reset forces mode 000, comparators off
// - sixteen taps, two ranges, power-down control
// - level is tap/24 or 1/4 plus tap/32
// - result one when plus input exceeds minus
//
// The APB interface to the registers was decided locally.
module cmpvr_ctrl (
    input  wire logic                     clock,
    input  wire logic                     rst_b,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [1:0]               cmp_raw,
    input  wire logic [4:0]               pin_in,
    output logic      [4:0]               pin_out,
    output logic      [4:0]               pin_oe,
    output cmpvr_pkg::cmpvr_cmp_cfg_s     cmp_cfg,
    output cmpvr_pkg::cmpvr_vref_s        vref_cfg,
    output logic      [6:0]               vref_level,
    output logic                          irq_request,
    output logic                          wake_request
);

    // register state
    logic [7:0] irq_ctrl;
    logic [2:0] cmp_mode;
    logic       input_switch;
    logic       change_flag;
    logic       change_en;
    logic [4:0] port_dir;
    logic [4:0] port_latch;
    logic       vref_power;
    logic       vref_pin;
    logic       vref_range;
    logic [3:0] vref_tap;
    logic [1:0] cmp_copy;
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] sync_c;
    logic [1:0] result;
    logic       cmp_powered;
    logic [6:0] next_level;
    logic [4:0] pin_sync_a;
    logic [4:0] pin_sync_b;
    logic [4:0] pin_sync_c;
    logic [4:0] pin_level;

    // bus decode
    logic       setup_phase;
    logic       access_phase;
    logic       addr_ok;
    logic [7:0] idx;
    logic       bus_write;
    logic       mapped;
    logic [7:0] next_rdata;
    logic [4:0] analog_mask;
    logic       mismatch;
    logic       cmp_access;
    logic       flag_write;

    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign idx          = paddr[9:2];
    assign addr_ok      = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
    assign bus_write    = access_phase & pwrite & pstrb[0] & addr_ok & ~pslverr;
    assign pready       = 1'b1;           // every access finishes in one access cycle

    // pins that each mode leaves as analog inputs
    always_comb begin
        if (cmp_mode == cmpvr_pkg::MODE_RESET) begin
            analog_mask = 5'h0F;
        end else if (cmp_mode == cmpvr_pkg::MODE_OFF) begin
            analog_mask = 5'h00;
        end else begin
            analog_mask = 5'h07;
        end
    end

    // address decode and read data selection
    always_comb begin
        next_rdata = 8'h00;
        mapped     = 1'b1;
        if (!addr_ok) begin
            mapped = 1'b0;
        end else if (idx == cmpvr_pkg::IDX_IRQ_CONTROL) begin
            next_rdata = irq_ctrl;
        end else if (idx == cmpvr_pkg::IDX_PERIPH_FLAGS) begin
            next_rdata = {1'b0, change_flag, 6'h00};
        end else if (idx == cmpvr_pkg::IDX_CMP_CONTROL) begin
            next_rdata = {result, 2'h0, input_switch, cmp_mode};
        end else if (idx == cmpvr_pkg::IDX_PORT_DATA) begin
            next_rdata = {3'h0, pin_level & ~analog_mask};
        end else if (idx == cmpvr_pkg::IDX_PORT_DIR) begin
            next_rdata = {3'h0, port_dir};
        end else if (idx == cmpvr_pkg::IDX_PERIPH_ENS) begin
            next_rdata = {1'b0, change_en, 6'h00};
        end else if (idx == cmpvr_pkg::IDX_VREF_CONTROL) begin
            next_rdata = {vref_power, vref_pin, vref_range, 1'b0, vref_tap};
        end else begin
            mapped = 1'b0;
        end
    end

    // read data and error captured in the setup cycle, shown in the access cycle
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata  <= {24'h00_0000, next_rdata};
            pslverr <= ~mapped;
        end
    end

    // interrupt control register, only the two enable bits matter here
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irq_ctrl <= cmpvr_pkg::RST_IRQ_CONTROL;
        end else if (bus_write && idx == cmpvr_pkg::IDX_IRQ_CONTROL) begin
            irq_ctrl <= pwdata[7:0];
        end
    end

    // comparator control; the result bits are never written
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cmp_mode     <= cmpvr_pkg::MODE_RESET;
            input_switch <= 1'b0;
        end else if (bus_write && idx == cmpvr_pkg::IDX_CMP_CONTROL) begin
            cmp_mode     <= pwdata[2:0];
            input_switch <= pwdata[cmpvr_pkg::BIT_SWITCH];
        end
    end

    // comparator power follows mode; off during and right after reset
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cmp_powered <= 1'b0;
        end else begin
            cmp_powered <= (cmp_mode != cmpvr_pkg::MODE_RESET) &&
                           (cmp_mode != cmpvr_pkg::MODE_OFF);
        end
    end

    assign cmp_cfg = '{powered: cmp_powered, input_switch: input_switch, mode: cmp_mode};

    // three-stage synchroniser for the asynchronous comparator outputs
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sync_a <= cmpvr_pkg::RST_RESULTS;
            sync_b <= cmpvr_pkg::RST_RESULTS;
            sync_c <= cmpvr_pkg::RST_RESULTS;
        end else begin
            sync_a <= cmp_raw;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // a bit changes once the second and third stages agree
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            result <= cmpvr_pkg::RST_RESULTS;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (sync_b[i] == sync_c[i]) begin
                    result[i] <= sync_c[i];
                end
            end
        end
    end

    // three-stage synchroniser for the port pins, which change at any time
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pin_sync_a <= 5'h00;
            pin_sync_b <= 5'h00;
            pin_sync_c <= 5'h00;
        end else begin
            pin_sync_a <= pin_in;
            pin_sync_b <= pin_sync_a;
            pin_sync_c <= pin_sync_b;
        end
    end

    // a pin level counts once the second and third stages agree
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pin_level <= 5'h00;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (pin_sync_b[i] == pin_sync_c[i]) begin
                    pin_level[i] <= pin_sync_c[i];
                end
            end
        end
    end

    // any access to the control register refreshes the copy
    assign cmp_access = access_phase & addr_ok & (idx == cmpvr_pkg::IDX_CMP_CONTROL);
    assign mismatch   = (result != cmp_copy);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cmp_copy <= cmpvr_pkg::RST_RESULTS;
        end else if (cmp_access) begin
            cmp_copy <= result;
        end
    end

    // change flag; a mismatch outside a control access wins over a clear
    assign flag_write = bus_write & (idx == cmpvr_pkg::IDX_PERIPH_FLAGS);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            change_flag <= 1'b0;
        end else if (mismatch && !cmp_access) begin
            change_flag <= 1'b1;
        end else if (flag_write) begin
            change_flag <= pwdata[cmpvr_pkg::BIT_CHANGE];
        end
    end

    // peripheral enable register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            change_en <= 1'b0;
        end else if (bus_write && idx == cmpvr_pkg::IDX_PERIPH_ENS) begin
            change_en <= pwdata[cmpvr_pkg::BIT_CHANGE];
        end
    end

    // interrupt gate and wake; wake never touches any register
    assign irq_request  = change_flag & change_en &
                          irq_ctrl[cmpvr_pkg::BIT_PERIPH_EN] &
                          irq_ctrl[cmpvr_pkg::BIT_GLOBAL_EN];
    assign wake_request = change_flag & change_en;

    // port direction and output latch
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            port_dir <= cmpvr_pkg::RST_PORT_DIR;
        end else if (bus_write && idx == cmpvr_pkg::IDX_PORT_DIR) begin
            port_dir <= pwdata[4:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            port_latch <= cmpvr_pkg::RST_PORT_LATCH;
        end else if (bus_write && idx == cmpvr_pkg::IDX_PORT_DATA) begin
            port_latch <= pwdata[4:0];
        end
    end

    // pin drivers; routed mode replaces the latch on pins 3 and 4 with the raw comparator outputs
    always_comb begin
        pin_out = port_latch;
        if (cmp_mode == cmpvr_pkg::MODE_ROUTED) begin
            pin_out[cmpvr_pkg::PIN_THREE] = cmp_raw[0];
            pin_out[cmpvr_pkg::PIN_FOUR]  = cmp_raw[1];
        end
    end

    assign pin_oe = ~port_dir;

    // reference control register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            vref_power <= 1'b0;
            vref_pin   <= 1'b0;
            vref_range <= 1'b0;
            vref_tap   <= 4'h0;
        end else if (bus_write && idx == cmpvr_pkg::IDX_VREF_CONTROL) begin
            vref_power <= pwdata[cmpvr_pkg::BIT_VREF_POWER];
            vref_pin   <= pwdata[cmpvr_pkg::BIT_VREF_PIN];
            vref_range <= pwdata[cmpvr_pkg::BIT_VREF_RANGE];
            vref_tap   <= pwdata[3:0];
        end
    end

    assign vref_cfg = '{power: vref_power, pin_out: vref_pin, range: vref_range, tap: vref_tap};

    // ladder level in supply/96 steps; zero while powered down
    always_comb begin
        if (!vref_power) begin
            next_level = 7'h00;
        end else if (vref_range) begin
            next_level = 7'({3'h0, vref_tap} * cmpvr_pkg::VREF_HIGH_STEP);
        end else begin
            next_level = 7'(cmpvr_pkg::VREF_LOW_BASE +
                            {3'h0, vref_tap} * cmpvr_pkg::VREF_LOW_STEP);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            vref_level <= 7'h00;
        end else begin
            vref_level <= next_level;
        end
    end

    // checks of the block's own behaviour
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    a_result_bits_ro: assert property (
        setup_phase && addr_ok && idx == cmpvr_pkg::IDX_CMP_CONTROL
        |=> prdata[7:6] == $past(result) && prdata[5:4] == 2'h0)
        else $error("control read does not show the results");

    a_routed_pins: assert property (
        cmp_mode == cmpvr_pkg::MODE_ROUTED
        |-> pin_out[4:3] == {cmp_raw[1], cmp_raw[0]})
        else $error("routed pins do not follow the comparators");

    a_dir_gates_oe: assert property (
        pin_oe == ~port_dir)
        else $error("pin enable does not follow direction");

    a_analog_reads_zero: assert property (
        setup_phase && addr_ok && idx == cmpvr_pkg::IDX_PORT_DATA
        |=> (prdata[4:0] & $past(analog_mask)) == 5'h00)
        else $error("analog pin read as one");

    a_change_sets_flag: assert property (
        mismatch && !cmp_access |=> change_flag)
        else $error("mismatch did not set the flag");

    a_flag_clear_write: assert property (
        flag_write && !pwdata[cmpvr_pkg::BIT_CHANGE] && (!mismatch || cmp_access)
        |=> !change_flag)
        else $error("flag clear ignored");

    a_flag_set_write: assert property (
        flag_write && pwdata[cmpvr_pkg::BIT_CHANGE] |=> change_flag)
        else $error("flag set by software ignored");

    a_irq_gating: assert property (
        irq_request |-> change_flag && change_en && irq_ctrl[7] && irq_ctrl[6])
        else $error("request without all enables");

    a_access_copy: assert property (
        cmp_access |=> cmp_copy == $past(result) && ($changed(result) || !mismatch))
        else $error("control access did not refresh copy");

    a_reset_mode: assert property (disable iff (1'b0)
        $rose(rst_b) |-> cmp_mode == cmpvr_pkg::MODE_RESET && !cmp_powered)
        else $error("reset left comparators configured");

    a_vref_high: assert property (
        vref_power && vref_range |=> vref_level == 7'($past(vref_tap) * 4))
        else $error("high range level wrong");

    c_routed_mode: cover property (cmp_mode == cmpvr_pkg::MODE_ROUTED && !pin_oe[3]);
    c_change_irq:  cover property (mismatch ##1 irq_request);
    c_clear_flow:  cover property (cmp_access ##[1:4] flag_write ##1 !change_flag);
    c_unmapped:    cover property (access_phase && pslverr);

endmodule

// ===== hw/cmpvr_pkg.sv
// package: register map, field positions, reset values and modes of the comparator block
package cmpvr_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_IRQ_CONTROL  = 8'h0B;
    localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_CMP_CONTROL  = 8'h1F;
    localparam logic [7:0] IDX_PORT_DATA    = 8'h05;
    localparam logic [7:0] IDX_PORT_DIR     = 8'h85;
    localparam logic [7:0] IDX_PERIPH_ENS   = 8'h8C;
    localparam logic [7:0] IDX_VREF_CONTROL = 8'h9F;

    // values after reset
    localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
    localparam logic [4:0] RST_PORT_DIR    = 5'h1F;
    localparam logic [4:0] RST_PORT_LATCH  = 5'h00;
    localparam logic [1:0] RST_RESULTS     = 2'h0;

    // field positions
    localparam int BIT_GLOBAL_EN  = 7;
    localparam int BIT_PERIPH_EN  = 6;
    localparam int BIT_CHANGE     = 6;
    localparam int BIT_SWITCH     = 3;
    localparam int BIT_VREF_POWER = 7;
    localparam int BIT_VREF_PIN   = 6;
    localparam int BIT_VREF_RANGE = 5;
    localparam int PIN_THREE      = 3;
    localparam int PIN_FOUR       = 4;

    // comparator mode field values
    localparam logic [2:0] MODE_RESET  = 3'h0;
    localparam logic [2:0] MODE_ROUTED = 3'h6;
    localparam logic [2:0] MODE_OFF    = 3'h7;

    // reference level in steps of supply/96 (common multiple of 24 and 32)
    localparam logic [6:0] VREF_HIGH_STEP = 7'h04;
    localparam logic [6:0] VREF_LOW_STEP  = 7'h03;
    localparam logic [6:0] VREF_LOW_BASE  = 7'h18;

    // configuration handed to the analog reference ladder
    typedef struct packed {
        logic       power;
        logic       pin_out;
        logic       range;
        logic [3:0] tap;
    } cmpvr_vref_s;

    // comparator mode and input switch handed to the analog comparators
    typedef struct packed {
        logic       powered;
        logic       input_switch;
        logic [2:0] mode;
    } cmpvr_cmp_cfg_s;

endpackage

// ===== sim/cmpvr_analog.sv
// analog side model: two comparators, ladder as minus input, and port pin wires
module cmpvr_analog (
    input  wire cmpvr_pkg::cmpvr_cmp_cfg_s cmp_cfg,
    input  wire logic [6:0]                vref_level,
    input  wire logic [13:0]               lvl_plus,
    input  wire logic [13:0]               lvl_minus,
    input  wire logic                      use_vref,
    input  wire logic [4:0]                pin_out,
    input  wire logic [4:0]                pin_oe,
    input  wire logic [4:0]                ext_level,
    output logic      [1:0]                cmp_raw,
    output logic      [4:0]                pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [6:0] minus_b;

    // second comparator may take the ladder output as its minus input
    assign minus_b = use_vref ? vref_level : lvl_minus[13:7];

    // a result is high only when plus exceeds minus; a powered-down comparator reads low
    assign cmp_raw[0] = cmp_cfg.powered & (lvl_plus[6:0] > lvl_minus[6:0]);
    assign cmp_raw[1] = cmp_cfg.powered & (lvl_plus[13:7] > minus_b);

    // a pin the device drives shows its value, otherwise the level outside
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ===== sim/comparator_interrupt_vref_ctrl_tb_top.sv
// self-checking bench for the comparator and reference control block
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
    $display("BAD %0t mismatch got %0h exp %0h", $time, (got), (exp)); end end
module comparator_interrupt_vref_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                      clock = 1'b0;
    logic                      rst_b = 1'b0;
    logic                      psel = 1'b0;
    logic                      penable = 1'b0;
    logic                      pwrite = 1'b0;
    logic [11:0]               paddr = 12'h000;
    logic [31:0]               pwdata = 32'h00000000;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic [1:0]                cmp_raw;
    logic [4:0]                pin_in;
    logic [4:0]                pin_out;
    logic [4:0]                pin_oe;
    cmpvr_pkg::cmpvr_cmp_cfg_s cmp_cfg;
    cmpvr_pkg::cmpvr_vref_s    vref_cfg;
    logic [6:0]                vref_level;
    logic                      irq_request;
    logic                      wake_request;
    logic [13:0]               lvl_plus = 14'h0000;
    logic [13:0]               lvl_minus = 14'h0000;
    logic [4:0]                ext_level = 5'h1F;
    int                        fails = 0;
    int                        n_compared = 0;

    cmpvr_ctrl dut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .cmp_cfg(cmp_cfg), .vref_cfg(vref_cfg),
        .vref_level(vref_level), .irq_request(irq_request), .wake_request(wake_request));

    cmpvr_analog far_side (.cmp_cfg(cmp_cfg), .vref_level(vref_level),
        .lvl_plus(lvl_plus), .lvl_minus(lvl_minus), .use_vref(1'b0), .pin_out(pin_out),
        .pin_oe(pin_oe), .ext_level(ext_level), .cmp_raw(cmp_raw), .pin_in(pin_in));

    // 50 MHz clock
    always #10 clock = ~clock;

    // counts, verdict and end of run
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one APB transfer: setup, access held until pready at a rising edge
    task automatic apb(input logic wr_en, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        int k;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= {2'h0, idx, 2'h0};
        pwdata  <= {24'h000000, wd};
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            fails++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 8'h00, r, e);
        `CHK(r, exp)
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // analog levels in supply/96 steps: {second, first}
    task automatic set_lv(input logic [6:0] p0, input logic [6:0] m0,
                          input logic [6:0] p1, input logic [6:0] m1);
        @(posedge clock);
        lvl_plus  <= {p1, p0};
        lvl_minus <= {m1, m0};
        #1;
    endtask

    // bounded wait for the change flag through the wake level
    task automatic wait_flag();
        int k;
        for (k = 0; k < 10 && wake_request !== 1'b1; k++) begin
            cycles(1);
        end
        if (k >= 10) begin
            fails++;
            test_done();
        end
    endtask

    // reset values, unmapped access and analog pins reading zero
    task automatic t_reset_map();
        logic [31:0] r;
        logic        e;
        rdchk(cmpvr_pkg::IDX_IRQ_CONTROL, 32'h00);
        rdchk(cmpvr_pkg::IDX_PERIPH_FLAGS, 32'h00);
        rdchk(cmpvr_pkg::IDX_CMP_CONTROL, 32'h00);
        rdchk(cmpvr_pkg::IDX_PORT_DIR, 32'h1F);
        rdchk(cmpvr_pkg::IDX_PERIPH_ENS, 32'h00);
        rdchk(cmpvr_pkg::IDX_VREF_CONTROL, 32'h00);
        `CHK(cmp_cfg.powered, 1'b0)
        rdchk(cmpvr_pkg::IDX_PORT_DATA, 32'h10);
        apb(1'b0, 8'h40, 8'h00, r, e);
        `CHK({e, r}, 33'h100000000)
    endtask

    // read-only results, change flag, clear order, enables and wake
    task automatic t_flag();
        wr(cmpvr_pkg::IDX_IRQ_CONTROL, 8'h00);
        set_lv(7'h28, 7'h14, 7'h0A, 7'h14);
        wr(cmpvr_pkg::IDX_CMP_CONTROL, 8'hC9);
        cycles(6);
        `CHK({cmp_cfg.input_switch, cmp_cfg.mode}, 4'h9)
        rdchk(cmpvr_pkg::IDX_CMP_CONTROL, 32'h49);
        wr(cmpvr_pkg::IDX_PERIPH_FLAGS, 8'h00);
        wr(cmpvr_pkg::IDX_PERIPH_ENS, 8'h40);
        wr(cmpvr_pkg::IDX_IRQ_CONTROL, 8'hC0);
        `CHK(irq_request, 1'b0)
        set_lv(7'h0A, 7'h14, 7'h0A, 7'h14);
        wait_flag();
        `CHK(irq_request, 1'b1)
        rdchk(cmpvr_pkg::IDX_PERIPH_FLAGS, 32'h40);
        wr(cmpvr_pkg::IDX_PERIPH_FLAGS, 8'h00);
        rdchk(cmpvr_pkg::IDX_PERIPH_FLAGS, 32'h40);
        rdchk(cmpvr_pkg::IDX_CMP_CONTROL, 32'h09);
        wr(cmpvr_pkg::IDX_PERIPH_FLAGS, 8'h00);
        rdchk(cmpvr_pkg::IDX_PERIPH_FLAGS, 32'h00);
        `CHK(irq_request, 1'b0)
        wr(cmpvr_pkg::IDX_PERIPH_FLAGS, 8'h40);
        `CHK(irq_request, 1'b1)
        wr(cmpvr_pkg::IDX_PERIPH_FLAGS, 8'h00);
        wr(cmpvr_pkg::IDX_IRQ_CONTROL, 8'h40);
        set_lv(7'h28, 7'h14, 7'h0A, 7'h14);
        wait_flag();
        `CHK(irq_request, 1'b0)
        rdchk(cmpvr_pkg::IDX_CMP_CONTROL, 32'h49);
        wr(cmpvr_pkg::IDX_IRQ_CONTROL, 8'h00);
    endtask

    // mode 110: raw results on pins 3 and 4, direction still gates them
    task automatic t_routed();
        wr(cmpvr_pkg::IDX_CMP_CONTROL, 8'h06);
        wr(cmpvr_pkg::IDX_PORT_DIR, 8'h08);
        cycles(4);
        `CHK(pin_oe, 5'h17)
        `CHK(pin_out[4:3], 2'b01)
        rdchk(cmpvr_pkg::IDX_PORT_DATA, 32'h08);
        @(posedge clock);
        lvl_plus <= {7'h3C, 7'h28};
        #2;
        `CHK(pin_out[4:3], 2'b11)
        wr(cmpvr_pkg::IDX_PORT_DIR, 8'h10);
        `CHK(pin_oe, 5'h0F)
    endtask

    // ladder taps and both ranges, then power down
    task automatic t_vref();
        logic [3:0] taps [3];
        logic [6:0] exp;
        taps = '{4'h0, 4'h9, 4'hF};
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 3; i++) begin
                wr(cmpvr_pkg::IDX_VREF_CONTROL, {1'b1, r[0], r[0], 1'b0, taps[i]});
                cycles(2);
                exp = r[0] ? {1'b0, taps[i], 2'b00} : 7'h18 + 7'(taps[i]) * 7'h03;
                `CHK(vref_level, exp)
                `CHK(vref_cfg, {1'b1, r[0], r[0], taps[i]})
            end
        end
        rdchk(cmpvr_pkg::IDX_VREF_CONTROL, 32'hEF);
        wr(cmpvr_pkg::IDX_VREF_CONTROL, 8'h0F);
        cycles(2);
        `CHK(vref_level, 7'h00)
    endtask

    // power off before sleep, then a reset in mid-run
    task automatic t_off_reset();
        wr(cmpvr_pkg::IDX_CMP_CONTROL, 8'h07);
        cycles(2);
        `CHK({cmp_cfg.powered, cmp_cfg.mode}, 4'h7)
        wr(cmpvr_pkg::IDX_CMP_CONTROL, 8'h01);
        cycles(2);
        @(posedge clock);
        rst_b <= 1'b0;
        cycles(2);
        `CHK({cmp_cfg.powered, cmp_cfg.mode}, 4'h0)
        @(posedge clock);
        rst_b <= 1'b1;
        rdchk(cmpvr_pkg::IDX_CMP_CONTROL, 32'h00);
        rdchk(cmpvr_pkg::IDX_PORT_DIR, 32'h1F);
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        t_reset_map();
        t_flag();
        t_routed();
        t_vref();
        t_off_reset();
        test_done();
    end
endmodule
